// [rtl/acmd_pkg.sv]
// Constants, register map and field layout of the audio clock mode and detect block
package acmd_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] ACMD_IDX_MODE     = 8'h22;
  localparam logic [7:0] ACMD_IDX_CYC_HI   = 8'h23;
  localparam logic [7:0] ACMD_IDX_CYC_LO   = 8'h24;
  localparam logic [7:0] ACMD_IDX_IGNORE   = 8'h25;
  localparam logic [7:0] ACMD_IDX_STATUS   = 8'h26;
  localparam logic [7:0] ACMD_IDX_IRQ_STAT = 8'h28;
  localparam logic [7:0] ACMD_IDX_IRQ_CLR  = 8'h29;
  localparam logic [7:0] ACMD_IDX_IRQ_EN   = 8'h2A;

  // Reset values
  localparam logic [7:0] ACMD_RST_MODE   = 8'h00;
  localparam logic [7:0] ACMD_RST_CYC_HI = 8'h01;
  localparam logic [7:0] ACMD_RST_CYC_LO = 8'h00;
  localparam logic [7:0] ACMD_RST_IGNORE = 8'h00;

  // Field positions and writable masks
  localparam int unsigned ACMD_MODE_INTERP_BIT = 4;
  localparam int unsigned ACMD_MODE_SPEED_LSB  = 0;
  localparam logic [7:0]  ACMD_MODE_WR_MASK    = 8'h13;
  localparam int unsigned ACMD_IGN_FS_BIT      = 6;
  localparam int unsigned ACMD_IGN_BCLK_BIT    = 5;
  localparam int unsigned ACMD_IGN_MCLK_BIT    = 4;
  localparam int unsigned ACMD_IGN_AUTO_BIT    = 1;
  localparam logic [7:0]  ACMD_IGN_WR_MASK     = 8'h72;

  // Speed band codes
  localparam logic [1:0] ACMD_SPEED_SINGLE = 2'h0;
  localparam logic [1:0] ACMD_SPEED_DOUBLE = 2'h1;
  localparam logic [1:0] ACMD_SPEED_QUAD   = 2'h2;

  // Interrupt bit positions
  localparam int unsigned ACMD_IRQ_W       = 5;
  localparam int unsigned ACMD_IRQ_CLKERR  = 0;
  localparam int unsigned ACMD_IRQ_FS      = 1;
  localparam int unsigned ACMD_IRQ_BCLK    = 2;
  localparam int unsigned ACMD_IRQ_MCLK    = 3;
  localparam int unsigned ACMD_IRQ_BAND    = 4;

  // Timing: rates in Hz, cycle counts derived from the core clock
  localparam int unsigned ACMD_CLK_HZ        = 200_000_000;
  localparam int unsigned ACMD_FS_MIN_HZ     = 8_000;
  localparam int unsigned ACMD_FS_MAX_HZ     = 192_000;
  localparam int unsigned ACMD_FS_SINGLE_HZ  = 48_000;
  localparam int unsigned ACMD_FS_DOUBLE_HZ  = 96_000;
  localparam int unsigned ACMD_FRAME_MAX_CYC = ACMD_CLK_HZ / ACMD_FS_MIN_HZ;
  localparam int unsigned ACMD_FRAME_MIN_CYC = ACMD_CLK_HZ / ACMD_FS_MAX_HZ;
  localparam int unsigned ACMD_SINGLE_CYC    = ACMD_CLK_HZ / ACMD_FS_SINGLE_HZ;
  localparam int unsigned ACMD_DOUBLE_CYC    = ACMD_CLK_HZ / ACMD_FS_DOUBLE_HZ;

  // Ratio limits
  localparam int unsigned ACMD_RATIO_W    = 11;
  localparam int unsigned ACMD_PERIOD_W   = 16;
  localparam int unsigned ACMD_BCLK_MIN   = 32;
  localparam int unsigned ACMD_BCLK_MAX   = 256;
  localparam int unsigned ACMD_MCLK_NUM   = 7;
  localparam int unsigned ACMD_MCLK_SLACK = 2;
  localparam int unsigned ACMD_MCLK_RATIOS [ACMD_MCLK_NUM] = '{128, 192, 256, 384, 512, 768, 1024};

endpackage : acmd_pkg

// [rtl/acmd_frame_meter.sv]
// Measures the frame period in core clock cycles and flags a missing frame sync
`timescale 1ns/1ps
`default_nettype none
module acmd_frame_meter
  import acmd_pkg::*;
#(
  parameter int unsigned MAX_CYC = ACMD_FRAME_MAX_CYC
)(
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  input  wire logic                     frame_sync,
  output logic                          frame_tick_ff,
  output logic [ACMD_PERIOD_W-1:0]      period_ff,
  output logic                          missing_ff
);

  logic                     sync_d_ff;
  logic [ACMD_PERIOD_W-1:0] cnt_ff;
  logic                     rise;

  assign rise = frame_sync & ~sync_d_ff;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_d_ff     <= 1'b0;
      cnt_ff        <= '0;
      period_ff     <= '0;
      frame_tick_ff <= 1'b0;
      missing_ff    <= 1'b0;
    end
    else
    begin
      sync_d_ff     <= frame_sync;
      frame_tick_ff <= rise;
      if (rise)
      begin
        period_ff  <= cnt_ff + 1'b1;
        cnt_ff     <= '0;
        missing_ff <= 1'b0;
      end
      // Saturate rather than wrap so a halted frame sync stays visible
      else if (cnt_ff >= ACMD_PERIOD_W'(MAX_CYC))
      begin
        missing_ff <= 1'b1;
      end
      else
      begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

endmodule : acmd_frame_meter
`default_nettype wire

// [rtl/acmd_ratio_meter.sv]
// Counts rising edges of a sampled clock per frame and reports frame-to-frame stability
`timescale 1ns/1ps
`default_nettype none
module acmd_ratio_meter
  import acmd_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  wire logic                    clk_sample,
  input  wire logic                    frame_tick,
  output logic [ACMD_RATIO_W-1:0]      ratio_ff,
  output logic                         stable_ff
);

  logic                    samp_d_ff;
  logic [ACMD_RATIO_W-1:0] cnt_ff;
  logic                    rise;

  // Sampled at core clock rate, so the measured clock must stay below half of it
  assign rise = clk_sample & ~samp_d_ff;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      samp_d_ff <= 1'b0;
      cnt_ff    <= '0;
      ratio_ff  <= '0;
      stable_ff <= 1'b0;
    end
    else
    begin
      samp_d_ff <= clk_sample;
      if (frame_tick)
      begin
        ratio_ff  <= cnt_ff;
        stable_ff <= (cnt_ff == ratio_ff);
        cnt_ff    <= {{(ACMD_RATIO_W-1){1'b0}}, rise};
      end
      else if (rise && cnt_ff != {ACMD_RATIO_W{1'b1}})
      begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

endmodule : acmd_ratio_meter
`default_nettype wire

// [rtl/acmd_top.sv]
// Audio clock mode selection, cycles-per-frame holding and clock fault supervision
`timescale 1ns/1ps
`default_nettype none
module acmd_top
  import acmd_pkg::*;
#(
  parameter int unsigned FRAME_MAX_CYC = ACMD_FRAME_MAX_CYC,
  parameter int unsigned SINGLE_CYC    = ACMD_SINGLE_CYC,
  parameter int unsigned DOUBLE_CYC    = ACMD_DOUBLE_CYC
)(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wr_data,
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  output logic      [7:0]  reg_rd_data,
  input  wire logic        bit_clk,
  input  wire logic        frame_sync,
  input  wire logic        master_clk,
  output logic             interp_16x,
  output logic      [1:0]  speed_band,
  output logic      [15:0] cycles_per_frame,
  output logic             auto_cfg_active,
  output logic             clock_error,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode

  localparam logic [7:0] ADDR_MODE     = 8'(4 * ACMD_IDX_MODE);
  localparam logic [7:0] ADDR_CYC_HI   = 8'(4 * ACMD_IDX_CYC_HI);
  localparam logic [7:0] ADDR_CYC_LO   = 8'(4 * ACMD_IDX_CYC_LO);
  localparam logic [7:0] ADDR_IGNORE   = 8'(4 * ACMD_IDX_IGNORE);
  localparam logic [7:0] ADDR_STATUS   = 8'(4 * ACMD_IDX_STATUS);
  localparam logic [7:0] ADDR_IRQ_STAT = 8'(4 * ACMD_IDX_IRQ_STAT);
  localparam logic [7:0] ADDR_IRQ_CLR  = 8'(4 * ACMD_IDX_IRQ_CLR);
  localparam logic [7:0] ADDR_IRQ_EN   = 8'(4 * ACMD_IDX_IRQ_EN);

  logic                  wr_mode;
  logic                  wr_cyc_hi;
  logic                  wr_cyc_lo;
  logic                  wr_ignore;
  logic                  wr_irq_clr;
  logic                  wr_irq_en;

  assign wr_mode    = reg_wr_en && (reg_addr == ADDR_MODE);
  assign wr_cyc_hi  = reg_wr_en && (reg_addr == ADDR_CYC_HI);
  assign wr_cyc_lo  = reg_wr_en && (reg_addr == ADDR_CYC_LO);
  assign wr_ignore  = reg_wr_en && (reg_addr == ADDR_IGNORE);
  assign wr_irq_clr = reg_wr_en && (reg_addr == ADDR_IRQ_CLR);
  assign wr_irq_en  = reg_wr_en && (reg_addr == ADDR_IRQ_EN);

  ////////////////////////////////////////////////////////////////////////////////
  // Software registers

  logic [7:0]            mode_ff;
  logic [7:0]            cyc_hi_ff;
  logic [7:0]            cyc_lo_ff;
  logic [7:0]            ignore_ff;
  logic [ACMD_IRQ_W-1:0] irq_en_ff;

  // Only documented fields hold state; reserved bits read back as zero
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_ff <= ACMD_RST_MODE;
    end
    else if (wr_mode)
    begin
      mode_ff <= reg_wr_data & ACMD_MODE_WR_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cyc_hi_ff <= ACMD_RST_CYC_HI;
      cyc_lo_ff <= ACMD_RST_CYC_LO;
    end
    else
    begin
      if (wr_cyc_hi)
      begin
        cyc_hi_ff <= reg_wr_data;
      end
      if (wr_cyc_lo)
      begin
        cyc_lo_ff <= reg_wr_data;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ignore_ff <= ACMD_RST_IGNORE;
    end
    else if (wr_ignore)
    begin
      ignore_ff <= reg_wr_data & ACMD_IGN_WR_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_en_ff <= '0;
    end
    else if (wr_irq_en)
    begin
      irq_en_ff <= reg_wr_data[ACMD_IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Measurement of the incoming audio clocks

  logic                     frame_tick;
  logic [ACMD_PERIOD_W-1:0] frame_period;
  logic                     frame_missing;
  logic [ACMD_RATIO_W-1:0]  bclk_ratio;
  logic                     bclk_stable;
  logic [ACMD_RATIO_W-1:0]  mclk_ratio;
  logic                     mclk_stable;

  acmd_frame_meter #(
    .MAX_CYC       (FRAME_MAX_CYC)
  ) u_frame_meter (
    .core_clk      (core_clk),
    .rst_n         (rst_n),
    .frame_sync    (frame_sync),
    .frame_tick_ff (frame_tick),
    .period_ff     (frame_period),
    .missing_ff    (frame_missing)
  );

  acmd_ratio_meter u_bclk_meter (
    .core_clk      (core_clk),
    .rst_n         (rst_n),
    .clk_sample    (bit_clk),
    .frame_tick    (frame_tick),
    .ratio_ff      (bclk_ratio),
    .stable_ff     (bclk_stable)
  );

  acmd_ratio_meter u_mclk_meter (
    .core_clk      (core_clk),
    .rst_n         (rst_n),
    .clk_sample    (master_clk),
    .frame_tick    (frame_tick),
    .ratio_ff      (mclk_ratio),
    .stable_ff     (mclk_stable)
  );

  // Results are judged one cycle after the tick, once the meters have latched
  logic judge_ff;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      judge_ff <= 1'b0;
    end
    else
    begin
      judge_ff <= frame_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Detectors

  logic fs_fault_ff;
  logic bclk_fault_ff;
  logic mclk_fault_ff;
  logic mclk_match;

  always_comb
  begin
    mclk_match = 1'b0;
    for (int i = 0; i < ACMD_MCLK_NUM; i++)
    begin
      if ((mclk_ratio + ACMD_RATIO_W'(ACMD_MCLK_SLACK) >= ACMD_RATIO_W'(ACMD_MCLK_RATIOS[i])) &&
          (mclk_ratio <= ACMD_RATIO_W'(ACMD_MCLK_RATIOS[i] + ACMD_MCLK_SLACK)))
      begin
        mclk_match = 1'b1;
      end
    end
  end

  // A halted frame sync condemns every detector, since none can measure
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fs_fault_ff   <= 1'b0;
      bclk_fault_ff <= 1'b0;
      mclk_fault_ff <= 1'b0;
    end
    else if (frame_missing)
    begin
      fs_fault_ff   <= 1'b1;
      bclk_fault_ff <= 1'b1;
      mclk_fault_ff <= 1'b1;
    end
    else if (judge_ff)
    begin
      fs_fault_ff   <= (frame_period < ACMD_PERIOD_W'(ACMD_FRAME_MIN_CYC));
      bclk_fault_ff <= !bclk_stable ||
                       (bclk_ratio < ACMD_RATIO_W'(ACMD_BCLK_MIN)) ||
                       (bclk_ratio > ACMD_RATIO_W'(ACMD_BCLK_MAX));
      mclk_fault_ff <= !mclk_match || !mclk_stable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Automatic configuration and effective modes

  logic                     auto_on;
  logic [1:0]               auto_band;
  logic [1:0]               nxt_band;
  logic [15:0]              nxt_cycles;
  logic [1:0]               band_ff;
  logic [15:0]              cycles_ff;
  logic                     interp_ff;

  assign auto_on = !ignore_ff[ACMD_IGN_AUTO_BIT];

  always_comb
  begin
    if (frame_period >= ACMD_PERIOD_W'(SINGLE_CYC))
    begin
      auto_band = ACMD_SPEED_SINGLE;
    end
    else if (frame_period >= ACMD_PERIOD_W'(DOUBLE_CYC))
    begin
      auto_band = ACMD_SPEED_DOUBLE;
    end
    else
    begin
      auto_band = ACMD_SPEED_QUAD;
    end
  end

  // Programmed band and count are bypassed in auto mode; the interpolation bit still follows mode_ff
  always_comb
  begin
    if (auto_on)
    begin
      nxt_band   = auto_band;
      nxt_cycles = frame_period;
    end
    else
    begin
      nxt_band   = mode_ff[ACMD_MODE_SPEED_LSB +: 2];
      nxt_cycles = {cyc_hi_ff, cyc_lo_ff};
    end
  end

  // Auto values only move on a fresh, valid measurement to avoid glitching
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      band_ff   <= ACMD_RST_MODE[ACMD_MODE_SPEED_LSB +: 2];
      cycles_ff <= {ACMD_RST_CYC_HI, ACMD_RST_CYC_LO};
    end
    else if (!auto_on || (judge_ff && !frame_missing))
    begin
      band_ff   <= nxt_band;
      cycles_ff <= nxt_cycles;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      interp_ff <= ACMD_RST_MODE[ACMD_MODE_INTERP_BIT];
    end
    else
    begin
      interp_ff <= mode_ff[ACMD_MODE_INTERP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Combined clock error

  logic fs_counts;
  logic bclk_counts;
  logic mclk_counts;
  logic clk_err_ff;

  assign fs_counts   = fs_fault_ff && !ignore_ff[ACMD_IGN_FS_BIT];
  assign bclk_counts = bclk_fault_ff && ignore_ff[ACMD_IGN_BCLK_BIT];
  assign mclk_counts = mclk_fault_ff && !ignore_ff[ACMD_IGN_MCLK_BIT];

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_err_ff <= 1'b0;
    end
    else
    begin
      clk_err_ff <= fs_counts || bclk_counts || mclk_counts;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupts

  logic [ACMD_IRQ_W-1:0] irq_stat_ff;
  logic [ACMD_IRQ_W-1:0] irq_event;
  logic                  clk_err_d_ff;
  logic [1:0]            band_d_ff;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_err_d_ff <= 1'b0;
      band_d_ff    <= ACMD_RST_MODE[ACMD_MODE_SPEED_LSB +: 2];
    end
    else
    begin
      clk_err_d_ff <= clk_err_ff;
      band_d_ff    <= band_ff;
    end
  end

  always_comb
  begin
    irq_event                 = '0;
    irq_event[ACMD_IRQ_CLKERR] = clk_err_ff && !clk_err_d_ff;
    irq_event[ACMD_IRQ_FS]     = judge_ff && fs_fault_ff;
    irq_event[ACMD_IRQ_BCLK]   = judge_ff && bclk_fault_ff;
    irq_event[ACMD_IRQ_MCLK]   = judge_ff && mclk_fault_ff;
    irq_event[ACMD_IRQ_BAND]   = band_ff != band_d_ff;
  end

  // A new event beats a clear landing in the same cycle
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_stat_ff <= '0;
    end
    else
    begin
      irq_stat_ff <= (irq_stat_ff & ~({ACMD_IRQ_W{wr_irq_clr}} & reg_wr_data[ACMD_IRQ_W-1:0])) | irq_event;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [7:0] rd_data_ff;
  logic [7:0] nxt_rd_data;

  always_comb
  begin
    nxt_rd_data = '0;
    unique case (reg_addr)
      ADDR_MODE:     nxt_rd_data = mode_ff;
      ADDR_CYC_HI:   nxt_rd_data = cyc_hi_ff;
      ADDR_CYC_LO:   nxt_rd_data = cyc_lo_ff;
      ADDR_IGNORE:   nxt_rd_data = ignore_ff;
      ADDR_STATUS:   nxt_rd_data = {2'h0, band_ff, mclk_fault_ff, bclk_fault_ff, fs_fault_ff, clk_err_ff};
      ADDR_IRQ_STAT: nxt_rd_data = 8'(irq_stat_ff);
      ADDR_IRQ_EN:   nxt_rd_data = 8'(irq_en_ff);
      default:       nxt_rd_data = '0;
    endcase
  end

  // Data only stand for the one cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data_ff <= '0;
    end
    else if (reg_rd_en)
    begin
      rd_data_ff <= nxt_rd_data;
    end
    else
    begin
      rd_data_ff <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rd_data      = rd_data_ff;
  assign interp_16x       = interp_ff;
  assign speed_band       = band_ff;
  assign cycles_per_frame = cycles_ff;
  assign auto_cfg_active  = auto_on;
  assign clock_error      = clk_err_ff;
  assign irq              = |(irq_stat_ff & irq_en_ff);

endmodule : acmd_top
`default_nettype wire

// [testbench/acmd_asserts.sv]
// Port-level checker for the audio clock mode and detect block
`timescale 1ns/1ps
`default_nettype none
module acmd_asserts
  import acmd_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wr_data,
  input wire logic        reg_wr_en,
  input wire logic        reg_rd_en,
  input wire logic [7:0]  reg_rd_data,
  input wire logic        bit_clk,
  input wire logic        frame_sync,
  input wire logic        master_clk,
  input wire logic        interp_16x,
  input wire logic [1:0]  speed_band,
  input wire logic [15:0] cycles_per_frame,
  input wire logic        auto_cfg_active,
  input wire logic        clock_error,
  input wire logic        irq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Shadow copies of the writable registers, rebuilt from bus writes
  logic [7:0] mode_ff;
  logic [7:0] hi_ff;
  logic [7:0] lo_ff;
  logic [7:0] ign_ff;
  logic [7:0] en_ff;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_ff <= 8'h00;
      hi_ff   <= 8'h01;
      lo_ff   <= 8'h00;
      ign_ff  <= 8'h00;
      en_ff   <= 8'h00;
    end
    else if (reg_wr_en)
    begin
      case (reg_addr)
        8'h88: mode_ff <= reg_wr_data & ACMD_MODE_WR_MASK;
        8'h8C: hi_ff <= reg_wr_data;
        8'h90: lo_ff <= reg_wr_data;
        8'h94: ign_ff <= reg_wr_data & ACMD_IGN_WR_MASK;
        8'hA8: en_ff <= reg_wr_data & 8'h1F;
        default: ;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  rd_idle_zero_a: assert property (!$past(reg_rd_en) |-> reg_rd_data == 8'h00)
    else $error("read data not zero outside read cycle");
  rd_mode_a: assert property ($past(reg_rd_en) && $past(reg_addr) == 8'h88 |-> reg_rd_data == $past(mode_ff))
    else $error("mode readback differs");
  rd_cyc_hi_a: assert property ($past(reg_rd_en) && $past(reg_addr) == 8'h8C |-> reg_rd_data == $past(hi_ff))
    else $error("cycle count high readback differs");
  auto_flag_a: assert property (auto_cfg_active == !ign_ff[ACMD_IGN_AUTO_BIT])
    else $error("auto flag does not follow disable bit");
  interp_sel_a: assert property (interp_16x == $past(mode_ff[ACMD_MODE_INTERP_BIT]))
    else $error("interpolation output does not follow mode bit");
  band_manual_a: assert property ($past(!auto_cfg_active) |-> speed_band == $past(mode_ff[1:0]))
    else $error("manual band not passed through");
  cycles_manual_a: assert property ($past(!auto_cfg_active) |-> cycles_per_frame == {$past(hi_ff), $past(lo_ff)})
    else $error("manual cycle count not passed through");
  err_masked_a: assert property (ign_ff[6:4] == 3'b101 && $past(ign_ff[6:4]) == 3'b101 |-> !clock_error)
    else $error("clock error with every detector ignored");
  irq_masked_a: assert property (en_ff == 8'h00 |-> !irq)
    else $error("interrupt with nothing enabled");
  clr_reads_zero_a: assert property ($past(reg_rd_en) && $past(reg_addr) == 8'hA4 |-> reg_rd_data == 8'h00)
    else $error("clear register read not zero");
endmodule : acmd_asserts

bind acmd_top acmd_asserts u_acmd_asserts (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
  .bit_clk(bit_clk), .frame_sync(frame_sync), .master_clk(master_clk), .interp_16x(interp_16x),
  .speed_band(speed_band), .cycles_per_frame(cycles_per_frame), .auto_cfg_active(auto_cfg_active),
  .clock_error(clock_error), .irq(irq));
`default_nettype wire

// [testbench/acmd_audio_src.sv]
// Audio source model: frame sync, bit clock and master clock built from core clock counts
`timescale 1ns/1ps
`default_nettype none
module acmd_audio_src
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        run,
  input  wire logic [15:0] frame_cyc,
  input  wire logic [7:0]  bclk_half,
  input  wire logic [7:0]  mclk_half,
  output logic             bit_clk,
  output logic             frame_sync,
  output logic             master_clk
);
  logic [15:0] f_ff;
  logic [7:0]  b_ff;
  logic [7:0]  m_ff;
  // Stopped source holds every line low, so the block sees a missing frame
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n || !run)
    begin
      f_ff       <= 16'h0000;
      b_ff       <= 8'h00;
      m_ff       <= 8'h00;
      bit_clk    <= 1'b0;
      frame_sync <= 1'b0;
      master_clk <= 1'b0;
    end
    else
    begin
      // Whole numbers of bit clocks per frame keep the ratio steady
      f_ff       <= (f_ff >= frame_cyc - 16'h0001) ? 16'h0000 : f_ff + 16'h0001;
      frame_sync <= f_ff < (frame_cyc >> 1);
      b_ff       <= (b_ff >= bclk_half - 8'h01) ? 8'h00 : b_ff + 8'h01;
      bit_clk    <= (b_ff >= bclk_half - 8'h01) ? !bit_clk : bit_clk;
      m_ff       <= (m_ff >= mclk_half - 8'h01) ? 8'h00 : m_ff + 8'h01;
      master_clk <= (m_ff >= mclk_half - 8'h01) ? !master_clk : master_clk;
    end
  end
endmodule : acmd_audio_src
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the audio clock mode and detect block
`timescale 1ns/1ps
`default_nettype none
module tb
  import acmd_pkg::*;
;
  logic        core_clk;
  logic        rst_n;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wr_data;
  logic        reg_wr_en;
  logic        reg_rd_en;
  logic [7:0]  reg_rd_data;
  logic        bit_clk;
  logic        frame_sync;
  logic        master_clk;
  logic        interp_16x;
  logic [1:0]  speed_band;
  logic [15:0] cycles_per_frame;
  logic        auto_cfg_active;
  logic        clock_error;
  logic        irq;
  logic        run;
  logic [15:0] frame_cyc;
  logic [7:0]  bclk_half;
  logic [7:0]  mclk_half;
  logic [31:0] seed = 32'hf358_1641;
  logic [7:0]  d;
  logic [7:0]  m;
  int          mismatches = 0;
  int          n_tests = 0;
  int          cyc = 0;
  localparam logic [7:0]  RA [5] = '{8'h88, 8'h8C, 8'h90, 8'h94, 8'h50};
  localparam logic [7:0]  RV [5] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
  localparam logic [15:0] FC [3] = '{16'd1536, 16'd2048, 16'd1280};
  localparam logic [7:0]  FB [3] = '{8'd12, 8'd16, 8'd10};
  localparam logic [7:0]  FM [3] = '{8'd3, 8'd4, 8'd5};
  // Fault table: bit clock half period, master clock half period, run, ignore bits, expected error
  localparam logic [7:0]  EB [7] = '{8'd12, 8'd48, 8'd48, 8'd12, 8'd12, 8'd12, 8'd12};
  localparam logic [7:0]  EM [7] = '{8'd3, 8'd3, 8'd3, 8'd5, 8'd5, 8'd3, 8'd3};
  localparam logic [6:0]  ER = 7'b1111100;
  localparam logic [7:0]  EI [7] = '{8'h20, 8'h20, 8'h00, 8'h00, 8'h10, 8'h50, 8'h10};
  localparam logic [6:0]  EE = 7'b0101001;
  ////////////////////////////////////////////////////////////////////////////////
  acmd_top #(.FRAME_MAX_CYC(3000), .SINGLE_CYC(2000), .DOUBLE_CYC(1500)) u_acmd_top (.core_clk(core_clk),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_rd_data(reg_rd_data), .bit_clk(bit_clk), .frame_sync(frame_sync), .master_clk(master_clk),
    .interp_16x(interp_16x), .speed_band(speed_band), .cycles_per_frame(cycles_per_frame),
    .auto_cfg_active(auto_cfg_active), .clock_error(clock_error), .irq(irq));
  acmd_audio_src u_acmd_audio_src (.core_clk(core_clk), .rst_n(rst_n), .run(run), .frame_cyc(frame_cyc),
    .bclk_half(bclk_half), .mclk_half(mclk_half), .bit_clk(bit_clk), .frame_sync(frame_sync),
    .master_clk(master_clk));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [1:0] exp_band(input logic [15:0] p);
    return (p >= 16'd2000) ? ACMD_SPEED_SINGLE : (p >= 16'd1500) ? ACMD_SPEED_DOUBLE : ACMD_SPEED_QUAD;
  endfunction : exp_band
  function automatic void rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
  endfunction : rnd
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr    <= a;
    reg_wr_data <= v;
    reg_wr_en   <= 1'b1;
    @(posedge core_clk);
    reg_wr_en   <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_rd_en <= 1'b1;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
    #1;
    v = reg_rd_data;
  endtask : rd
  task automatic frames(input int n);
    #1;
    repeat (n * int'(frame_cyc)) @(posedge core_clk);
    #1;
  endtask : frames
  task automatic tally_and_finish();
    $display("mismatches %0d of %0d comparisons", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Ceiling well above the roughly 62600 cycles the sequence needs
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 95000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial
  begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wr_data = 8'h00;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    run = 1'b0;
    frame_cyc = 16'd1536;
    bclk_half = 8'd12;
    mclk_half = 8'd3;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    chk("cycles", cycles_per_frame, 16'h0100);
    chk("auto", auto_cfg_active, 1'b1);
    for (int i = 0; i < 5; i++)
    begin
      rd(RA[i], d);
      chk("reset value", d, RV[i]);
    end
    // Manual mode: every band code, random interpolation and counts, random reserved bits
    wr(8'h94, 8'h02);
    for (int i = 0; i < 6; i++)
    begin
      rnd();
      m = {seed[7:2], 2'(i % 3)};
      wr(8'h88, m);
      wr(8'h8C, seed[15:8]);
      wr(8'h90, seed[23:16]);
      @(posedge core_clk);
      #1;
      chk("interp", interp_16x, m[4]);
      chk("band", speed_band, m[1:0]);
      chk("cycles", cycles_per_frame, {seed[15:8], seed[23:16]});
      rd(8'h88, d);
      chk("mode read", d, m & 8'h13);
    end
    wr(8'h8C, 8'h06);
    wr(8'h90, 8'h00);
    wr(8'h94, 8'h20);
    run <= 1'b1;
    // Auto mode ignores the programmed quad band and count
    for (int i = 0; i < 3; i++)
    begin
      @(posedge core_clk);
      frame_cyc <= FC[i];
      bclk_half <= FB[i];
      mclk_half <= FM[i];
      frames(4);
      chk("auto band", speed_band, exp_band(FC[i]));
      chk("auto cycles", cycles_per_frame, FC[i]);
      chk("error", clock_error, 1'b0);
    end
    wr(8'hA4, 8'h1F);
    frame_cyc <= FC[0];
    wr(8'hA8, 8'h01);
    for (int i = 0; i < 7; i++)
    begin
      wr(8'h94, EI[i]);
      run <= ER[6 - i];
      bclk_half <= EB[i];
      mclk_half <= EM[i];
      frames(4);
      chk("clock error", clock_error, EE[6 - i]);
    end
    rd(8'hA0, d);
    chk("irq status", d[0], 1'b1);
    rd(8'h98, d);
    chk("status", d, 8'h1F);
    chk("irq", irq, 1'b1);
    wr(8'hA8, 8'h00);
    #1;
    chk("irq masked", irq, 1'b0);
    wr(8'hA8, 8'h01);
    #1;
    chk("irq unmasked", irq, 1'b1);
    wr(8'hA4, 8'h01);
    #1;
    chk("irq cleared", irq, 1'b0);
    rd(8'hA4, d);
    chk("clear read", d, 8'h00);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
